/* File: common/dss_map.svh */
// Register offsets, field positions, reset values and timing counts of the socket control block.
`ifndef DSS_MAP_SVH
`define DSS_MAP_SVH
`define DSS_OFS_STATUS 8'h0c
`define DSS_OFS_INTR 8'h10
`define DSS_OFS_MASK 8'h14
`define DSS_OFS_COUNT 8'h08
`define DSS_OFS_SIZE 8'h04
`define DSS_OFS_DSCR 8'h00
`define DSS_B_GO_ENABLE 31
`define DSS_B_GO_SUSPEND 30
`define DSS_B_UNIT 29
`define DSS_B_WRAPUP 28
`define DSS_B_SUSP_EOP 27
`define DSS_B_SUSP_TRANS 26
`define DSS_B_SUSP_LAST 25
`define DSS_B_SUSP_SHORT 24
`define DSS_B_EN_CONS 23
`define DSS_B_EN_PROD 22
`define DSS_B_CLIP 21
`define DSS_B_SPARE_ON 10
`define DSS_F_MIN_HI 9
`define DSS_F_MIN_LO 5
`define DSS_F_IDX_HI 15
`define DSS_F_PEND_HI 23
`define DSS_F_PEND_LO 16
`define DSS_F_WM_HI 31
`define DSS_F_WM_LO 24
`define DSS_SPARE_MAX 5'h1f
`define DSS_I_LAST 9
`define DSS_I_SHORT 8
`define DSS_I_TDONE 7
`define DSS_I_ERROR 6
`define DSS_I_SUSPEND 5
`define DSS_I_STALL 4
`define DSS_I_NODSCR 3
`define DSS_I_LOW 2
`define DSS_I_CONS 1
`define DSS_I_PROD 0
`define DSS_CTRL_RESET 32'h04e00000
`define DSS_CTRL_WMASK 32'hffe007e0
`define DSS_INTR_MASK10 10'h3ff
`define DSS_NO_DSCR 16'hffff
`define DSS_PH_LOAD 3'h0
`define DSS_PH_STALL 3'h1
`define DSS_PH_ACTIVE 3'h2
`define DSS_PH_EVENT 3'h3
`define DSS_PH_CHKA 3'h4
`define DSS_PH_SUSP 3'h5
`define DSS_PH_CHKB 3'h6
`define DSS_PH_WAIT 3'h7
`define DSS_ENABLE_LAG_NS 16
`define DSS_CLK_NS 8
`define DSS_ENABLE_LAG_CYC ((`DSS_ENABLE_LAG_NS + `DSS_CLK_NS - 1) / `DSS_CLK_NS)
`endif

/* File: common/dss_pkg.sv */
// Types shared by the socket control block.
package dss_pkg;
  typedef enum logic [2:0] {
    DSS_LOAD, DSS_STALL, DSS_ACTIVE, DSS_EVENT, DSS_CHKA, DSS_SUSP, DSS_CHKB, DSS_WAIT
  } dss_phase_e;
  typedef logic [31:0] dss_word_t;
endpackage : dss_pkg

/* File: rtl/dss_socket.sv */
// Control, status and interrupt logic of one buffer-adapter DMA socket.
// Behaviour
// - Clearing run aborts transfer, no write-back.
// - Run rising reloads descriptor; running flag lags.
// - Suspend request suspends after current descriptor.
// - Resume only on suspend request falling.
// - Count unit selects descriptors or bytes.
// - Force-wrap ends buffer now, counts update.
// - Stop-on-packet-end suspends after EOP buffer.
// - Stop-on-limit suspends when total reaches limit.
// - Stop-before-final suspends, sets bit nine.
// - Egress short buffer suspends, sets bit eight.
// - Notice enables gate events and write-back.
// - Clip fill bytes so ingress stays within limit.
// - Suspend at completion advances index; resume loads unless none.
// - Three-bit phase code readable by software.
// - Core EOP enters check, then active or event.
// - Spare gate stalls until tally meets threshold.
// - Spare tally counts events in, activations out.
// - Request bits set by hardware, write-one clear.
// - Error causes set error bit with suspend.
// - Suspend, stall, no-descriptor bits stay sticky.
// - Limit-hit only with stop-on-limit; EOP total rule.
// - Supply-low sets at watermark, stays sticky.
// - Supply low when pending at or under watermark.
// - Total updates only at descriptor completion.
// - Mask bit one lets request reach the CPU.
`timescale 1ns/1ps
`include "dss_map.svh"
module dss_socket (
  input wire logic clk, // Interconnect clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  input wire logic [7:0] reg_addr, // Register byte offset.
  input wire dss_pkg::dss_word_t reg_wdata, // Register write data.
  output dss_pkg::dss_word_t reg_rdata, // Register read data.
  input wire logic egress, // Socket direction, one for egress.
  input wire logic dscr_ready, // Loaded descriptor has space or data.
  input wire logic dscr_loaded, // Descriptor load from memory finished.
  input wire logic [15:0] dscr_next, // Next index from the chain.
  input wire logic [15:0] dscr_fill, // Fill bytes of the loaded descriptor.
  input wire logic [15:0] dscr_cap, // Capacity in bytes of the descriptor.
  input wire logic dscr_eop, // Descriptor carries end of packet.
  input wire logic dscr_err, // Descriptor already flags an error.
  input wire logic core_eop, // End-of-packet request from the core.
  input wire logic core_done, // Core filled or drained the buffer.
  input wire logic core_bad, // Core wrote inactive socket or left data.
  input wire logic event_in, // Event received from a peer.
  input wire logic event_in_cons, // Received event is a consume notice.
  input wire logic event_sent, // Outgoing event confirmed.
  output logic dscr_load_req, // Request descriptor load.
  output logic [15:0] dscr_index, // Current descriptor index.
  output logic writeback_req, // Write descriptor back to memory.
  output logic event_out, // Send notice to peer.
  output logic [15:0] clipped_fill, // Fill bytes after clipping.
  output logic abort, // Abort ongoing transfer.
  output logic flush, // Discard fetch data and flush writes.
  output logic spare_ready, // More than the current buffer available.
  output logic irq // Masked interrupt to the CPU.
);
  import dss_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [9:0] intr;
    logic [9:0] mask;
    logic [31:0] total;
    logic [31:0] limit;
    logic [15:0] index;
    logic [7:0] pending;
    logic [7:0] watermark;
    logic [4:0] spare;
    logic [4:0] spare_min;
    logic [1:0] lag;
    logic enabled;
    logic go_q;
    logic susp_q;
    logic clear_ok;
    dss_phase_e phase;
    logic [15:0] fill;
    logic [31:0] rdata;
  } dss_state_s;

  dss_state_s st_reg;
  dss_state_s st_next;

  function automatic logic [31:0] dss_sum(input logic [31:0] a, input logic [15:0] b);
    dss_sum = a + {16'h0000, b};
  endfunction : dss_sum

  logic unit_desc;
  logic [15:0] fill_clip;
  logic [9:0] hw_set;
  logic over_limit;
  logic wrap_keep;

  always_comb begin
    unit_desc = st_reg.ctrl[`DSS_B_UNIT];
    fill_clip = dscr_fill;
    // Clipping only makes sense while the total counts bytes.
    if (st_reg.ctrl[`DSS_B_CLIP] && !egress && !unit_desc && st_reg.limit != 32'h0 &&
        dss_sum(st_reg.total, dscr_fill) >= st_reg.limit) begin
      fill_clip = 16'(st_reg.limit - st_reg.total);
    end
    // Forecast of the total once the descriptor in hand has completed.
    over_limit = st_reg.limit != 32'h0 &&
                 dss_sum(st_reg.total, unit_desc ? 16'h0001 : st_reg.fill) >= st_reg.limit;
  end

  always_comb begin
    st_next = st_reg;
    hw_set = 10'h000;
    wrap_keep = 1'b0;
    st_next.go_q = st_reg.ctrl[`DSS_B_GO_ENABLE];
    st_next.susp_q = st_reg.ctrl[`DSS_B_GO_SUSPEND];
    // Enabled follows run after a short fixed lag.
    if (st_reg.enabled != st_reg.ctrl[`DSS_B_GO_ENABLE]) begin
      if (st_reg.lag == 2'(`DSS_ENABLE_LAG_CYC)) begin
        st_next.enabled = st_reg.ctrl[`DSS_B_GO_ENABLE];
        st_next.lag = 2'h0;
      end else begin
        st_next.lag = st_reg.lag + 2'h1;
      end
    end else begin
      st_next.lag = 2'h0;
    end
    if (event_in) begin
      // The tally saturates at both ends rather than wrapping.
      if (st_reg.spare != `DSS_SPARE_MAX) begin
        st_next.spare = st_reg.spare + 5'h01;
      end
      hw_set[event_in_cons ? `DSS_I_CONS : `DSS_I_PROD] = 1'b1;
    end
    case (st_reg.phase)
      DSS_LOAD: begin
        if (st_reg.enabled && st_reg.index == `DSS_NO_DSCR) begin
          hw_set[`DSS_I_NODSCR] = 1'b1;
          hw_set[`DSS_I_SUSPEND] = 1'b1;
          st_next.phase = DSS_SUSP;
        end else if (st_reg.enabled && dscr_loaded) begin
          st_next.fill = fill_clip;
          if (dscr_err || dscr_fill > dscr_cap) begin
            hw_set[`DSS_I_ERROR] = 1'b1;
            hw_set[`DSS_I_SUSPEND] = 1'b1;
            st_next.phase = DSS_SUSP;
          end else if (st_reg.ctrl[`DSS_B_SUSP_LAST] && st_reg.limit != 32'h0 &&
                       dss_sum(st_reg.total, unit_desc ? 16'h0001 : dscr_cap) >= st_reg.limit) begin
            hw_set[`DSS_I_LAST] = 1'b1;
            hw_set[`DSS_I_SUSPEND] = 1'b1;
            st_next.phase = DSS_SUSP;
          end else if (egress && st_reg.ctrl[`DSS_B_SUSP_SHORT] && dscr_fill < dscr_cap) begin
            hw_set[`DSS_I_SHORT] = 1'b1;
            hw_set[`DSS_I_SUSPEND] = 1'b1;
            st_next.phase = DSS_SUSP;
          end else begin
            st_next.phase = DSS_STALL;
          end
        end
      end
      DSS_STALL: begin
        if (!dscr_ready) begin
          hw_set[`DSS_I_STALL] = 1'b1;
        end else if (!st_reg.ctrl[`DSS_B_SPARE_ON] || st_reg.spare >= st_reg.spare_min) begin
          st_next.phase = DSS_ACTIVE;
          if (st_next.spare != 5'h00) begin
            st_next.spare = st_next.spare - 5'h01;
          end
        end
      end
      DSS_ACTIVE: begin
        if (core_bad) begin
          hw_set[`DSS_I_ERROR] = 1'b1;
          hw_set[`DSS_I_SUSPEND] = 1'b1;
          st_next.phase = DSS_SUSP;
        end else if (st_reg.ctrl[`DSS_B_WRAPUP] || core_done) begin
          st_next.phase = DSS_EVENT;
        end else if (core_eop) begin
          st_next.phase = DSS_CHKA;
        end
      end
      DSS_CHKA: st_next.phase = DSS_CHKB;
      DSS_CHKB: begin
        // Ingress EOP leaves total alone unless the limit forces a suspend or stop-on-packet-end is set.
        if (egress || (st_reg.ctrl[`DSS_B_SUSP_TRANS] && over_limit) ||
            st_reg.ctrl[`DSS_B_SUSP_EOP]) begin
          st_next.phase = DSS_EVENT;
        end else begin
          st_next.phase = DSS_ACTIVE;
        end
      end
      DSS_EVENT: begin
        st_next.total = dss_sum(st_reg.total,
                                unit_desc ? 16'h0001 : st_reg.fill);
        st_next.ctrl[`DSS_B_WRAPUP] = 1'b0;
        st_next.index = dscr_next;
        st_next.pending = st_reg.pending - 8'h01;
        if (st_reg.pending - 8'h01 <= st_reg.watermark) begin
          hw_set[`DSS_I_LOW] = 1'b1;
        end
        st_next.phase = (egress ? st_reg.ctrl[`DSS_B_EN_CONS] : st_reg.ctrl[`DSS_B_EN_PROD]) ?
                        DSS_WAIT : DSS_LOAD;
        if (egress ? st_reg.ctrl[`DSS_B_EN_CONS] : st_reg.ctrl[`DSS_B_EN_PROD]) begin
          hw_set[egress ? `DSS_I_CONS : `DSS_I_PROD] = 1'b1;
        end
        if (st_reg.ctrl[`DSS_B_SUSP_TRANS] && over_limit) begin
          hw_set[`DSS_I_TDONE] = 1'b1;
        end
        if ((st_reg.ctrl[`DSS_B_SUSP_TRANS] && over_limit) || st_reg.ctrl[`DSS_B_GO_SUSPEND] ||
            (st_reg.ctrl[`DSS_B_SUSP_EOP] && dscr_eop)) begin
          hw_set[`DSS_I_SUSPEND] = 1'b1;
          st_next.phase = DSS_SUSP;
        end
      end
      DSS_WAIT: begin
        if (event_sent) begin
          st_next.phase = DSS_LOAD;
        end
      end
      DSS_SUSP: begin
        if (st_reg.susp_q && !st_reg.ctrl[`DSS_B_GO_SUSPEND]) begin
          st_next.clear_ok = 1'b1;
        end
        if (st_reg.clear_ok && st_reg.intr[`DSS_I_LAST:`DSS_I_SUSPEND] == 5'h00 &&
            !st_reg.ctrl[`DSS_B_GO_SUSPEND]) begin
          st_next.clear_ok = 1'b0;
          st_next.phase = DSS_LOAD;
        end
      end
      default: st_next.phase = DSS_LOAD;
    endcase
    if (reg_wr) begin
      case (reg_addr)
        `DSS_OFS_STATUS: begin
          wrap_keep = st_next.ctrl[`DSS_B_WRAPUP];
          st_next.ctrl = reg_wdata & `DSS_CTRL_WMASK;
          // Force-wrap is write-one-to-set; only a finished wrap-up clears it.
          st_next.ctrl[`DSS_B_WRAPUP] = reg_wdata[`DSS_B_WRAPUP] | wrap_keep;
          st_next.spare_min = reg_wdata[`DSS_F_MIN_HI:`DSS_F_MIN_LO];
        end
        `DSS_OFS_INTR: st_next.intr = st_reg.intr & ~reg_wdata[9:0];
        `DSS_OFS_MASK: st_next.mask = reg_wdata[9:0];
        `DSS_OFS_SIZE: st_next.limit = reg_wdata;
        `DSS_OFS_COUNT: st_next.total = reg_wdata;
        `DSS_OFS_DSCR: begin
          st_next.index = reg_wdata[`DSS_F_IDX_HI:0];
          st_next.pending = reg_wdata[`DSS_F_PEND_HI:`DSS_F_PEND_LO];
          st_next.watermark = reg_wdata[`DSS_F_WM_HI:`DSS_F_WM_LO];
        end
        default: st_next.ctrl = st_next.ctrl;
      endcase
    end
    st_next.intr = st_next.intr | hw_set;
    // Clearing run drops the socket at once; enabled follows after the lag.
    if (!st_reg.ctrl[`DSS_B_GO_ENABLE]) begin
      st_next.intr = 10'h000;
      st_next.phase = DSS_LOAD;
      st_next.clear_ok = 1'b0;
    end
    if (st_reg.ctrl[`DSS_B_GO_ENABLE] && !st_reg.go_q) begin
      st_next.phase = DSS_LOAD;
    end
    st_next.rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `DSS_OFS_STATUS: st_next.rdata = {st_reg.ctrl[`DSS_B_GO_ENABLE:`DSS_B_CLIP],
                         st_reg.enabled, st_reg.phase == DSS_SUSP, 1'b0,
                         3'(st_reg.phase), 4'h0,
                         st_reg.ctrl[`DSS_B_SPARE_ON], st_reg.spare_min, st_reg.spare};
        `DSS_OFS_INTR: st_next.rdata = {22'h0, st_reg.intr};
        `DSS_OFS_MASK: st_next.rdata = {22'h0, st_reg.mask};
        `DSS_OFS_SIZE: st_next.rdata = st_reg.limit;
        `DSS_OFS_COUNT: st_next.rdata = st_reg.total;
        `DSS_OFS_DSCR: st_next.rdata = {st_reg.watermark, st_reg.pending, st_reg.index};
        default: st_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.ctrl <= `DSS_CTRL_RESET;
      st_reg.index <= `DSS_NO_DSCR;
      st_reg.phase <= DSS_LOAD;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign dscr_index = st_reg.index;
  assign clipped_fill = st_reg.fill;
  // Nothing is loaded or written back once run is cleared, even while enabled lags.
  assign dscr_load_req = st_reg.phase == DSS_LOAD && st_reg.enabled &&
                         st_reg.ctrl[`DSS_B_GO_ENABLE] &&
                         st_reg.index != `DSS_NO_DSCR;
  assign writeback_req = st_reg.phase == DSS_EVENT && st_reg.ctrl[`DSS_B_GO_ENABLE] &&
                         (egress ? st_reg.ctrl[`DSS_B_EN_CONS] :
                          st_reg.ctrl[`DSS_B_EN_PROD]);
  assign event_out = writeback_req;
  assign abort = st_reg.enabled && !st_reg.ctrl[`DSS_B_GO_ENABLE];
  assign flush = st_reg.phase == DSS_ACTIVE && st_reg.ctrl[`DSS_B_WRAPUP];
  assign spare_ready = st_reg.ctrl[`DSS_B_SPARE_ON] && st_reg.spare != 5'h00;
  assign irq = |(st_reg.intr & st_reg.mask);
endmodule : dss_socket

/* File: dv/dss_socket_assertions.sv */
// Concurrent checks on the ports of the socket control block.
`timescale 1ns/1ps
module dss_socket_assertions
  import dss_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic srst, // Reset.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [7:0] reg_addr, // Offset.
  input wire dss_pkg::dss_word_t reg_wdata, // Write data.
  input wire dss_pkg::dss_word_t reg_rdata, // Read data.
  input wire logic dscr_load_req, // Load request.
  input wire logic [15:0] dscr_index, // Index.
  input wire logic writeback_req, // Write-back.
  input wire logic event_out, // Notice out.
  input wire logic abort, // Abort.
  input wire logic irq // Interrupt.
);
  logic mask_seen_reg;
  logic run_seen_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_seen_reg <= 1'b0;
      run_seen_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h14 && reg_wdata[9:0] != 10'h000) mask_seen_reg <= 1'b1;
      if (reg_addr == 8'h0c && reg_wdata[31]) run_seen_reg <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data not zero while idle");
  a_load_has_index: assert property (dscr_load_req |-> dscr_index != 16'hffff)
    else $error("load requested with no descriptor");
  a_event_with_wb: assert property (event_out |-> writeback_req ##1 !writeback_req)
    else $error("notice without write-back or longer than one cycle");
  a_abort_quiet: assert property (abort |-> !writeback_req && !event_out)
    else $error("write-back or notice during abort");
  a_load_after_run: assert property (dscr_load_req |-> run_seen_reg)
    else $error("load before run was requested");
  a_irq_needs_mask: assert property (irq |-> mask_seen_reg)
    else $error("interrupt with mask never set");
  a_reset_quiet: assert property ($fell(srst) |-> !irq && dscr_index == 16'hffff)
    else $error("state not cleared by reset");
  a_mask_off_irq: assert property ((reg_wr && reg_addr == 8'h14 && reg_wdata == 32'h0) |=> !irq)
    else $error("interrupt with mask cleared");
  c_event: cover property (event_out);
  c_irq: cover property (irq);
  c_load: cover property (dscr_load_req ##1 !dscr_load_req);
endmodule : dss_socket_assertions

/* File: dv/dss_partner.sv */
// Behavioural fetch logic and core beside the socket.
`timescale 1ns/1ps
module dss_partner (
  input wire logic clk, // Clock.
  input wire logic srst, // Reset.
  input wire logic slow, // Answer slowly.
  input wire logic dscr_load_req, // Load request.
  input wire logic [15:0] dscr_index, // Index.
  input wire logic event_out, // Notice out.
  output logic dscr_ready, // Descriptor ready.
  output logic dscr_loaded, // Load finished.
  output logic [15:0] dscr_next, // Next index.
  output logic [15:0] dscr_fill, // Fill bytes.
  output logic [15:0] dscr_cap, // Capacity.
  output logic core_done, // Buffer done.
  output logic event_sent // Notice confirmed.
);
  logic [3:0] cnt_reg;
  assign dscr_next = dscr_index + 16'h0001;
  assign dscr_fill = 16'h0040;
  assign dscr_cap = 16'h0040;
  // Load answer after two or seven cycles, core finishes the buffer eight cycles later.
  always_ff @(posedge clk) begin
    dscr_loaded <= 1'b0;
    core_done <= 1'b0;
    event_sent <= event_out && !event_sent;
    if (srst) begin
      cnt_reg <= 4'h0;
      dscr_ready <= 1'b0;
      event_sent <= 1'b0;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
      dscr_loaded <= (cnt_reg == 4'h9);
      core_done <= (cnt_reg == 4'h1);
    end else if (dscr_load_req) begin
      dscr_ready <= 1'b1;
      cnt_reg <= slow ? 4'hf : 4'ha;
    end
  end
endmodule : dss_partner

/* File: dv/dss_socket_bench.sv */
// Self-checking bench of the socket control block.
`timescale 1ns/1ps
module dss_socket_bench;
  import dss_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; dss_word_t d;} dss_row_s;
  logic clk, srst, reg_wr, reg_rd, egress, dscr_eop, dscr_err, core_eop, core_bad;
  logic event_in, event_in_cons, slow, dscr_ready, dscr_loaded, core_done, event_sent;
  logic dscr_load_req, writeback_req, event_out, abort, flush, spare_ready, irq, ok;
  logic [7:0] reg_addr;
  logic [15:0] dscr_next, dscr_fill, dscr_cap, dscr_index, clipped_fill;
  dss_word_t reg_wdata, reg_rdata, d;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  dss_row_s rows [9];
  dss_socket dss_socket_inst (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .egress(egress),
    .dscr_ready(dscr_ready), .dscr_loaded(dscr_loaded), .dscr_next(dscr_next),
    .dscr_fill(dscr_fill), .dscr_cap(dscr_cap), .dscr_eop(dscr_eop), .dscr_err(dscr_err),
    .core_eop(core_eop), .core_done(core_done), .core_bad(core_bad), .event_in(event_in),
    .event_in_cons(event_in_cons), .event_sent(event_sent), .dscr_load_req(dscr_load_req),
    .dscr_index(dscr_index), .writeback_req(writeback_req), .event_out(event_out),
    .clipped_fill(clipped_fill), .abort(abort), .flush(flush), .spare_ready(spare_ready),
    .irq(irq));
  dss_partner dss_partner_inst (.clk(clk), .srst(srst), .slow(slow),
    .dscr_load_req(dscr_load_req), .dscr_index(dscr_index), .event_out(event_out),
    .dscr_ready(dscr_ready), .dscr_loaded(dscr_loaded), .dscr_next(dscr_next),
    .dscr_fill(dscr_fill), .dscr_cap(dscr_cap), .core_done(core_done), .event_sent(event_sent));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic c, input string m);
    tests_run++;
    if (c !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input dss_word_t v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output dss_word_t v);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask : rd
  task automatic poll(input logic [7:0] a, input dss_word_t m, input dss_word_t v, output logic r);
    dss_word_t x;
    r = 1'b0;
    for (int i = 0; i < 60 && !r; i++) begin
      rd(a, x);
      r = ((x & m) === v);
    end
  endtask : poll
  task automatic pulse_event(input logic cons);
    @(negedge clk);
    event_in = 1'b1;
    event_in_cons = cons;
    @(negedge clk);
    event_in = 1'b0;
  endtask : pulse_event
  task automatic limit_case(input dss_word_t c, input dss_word_t n, input dss_word_t m,
                            input dss_word_t t);
    wr(8'h0c, 32'h04e00000);
    wr(8'h08, 32'h0);
    wr(8'h04, n);
    wr(8'h00, 32'h01020000);
    wr(8'h0c, c);
    poll(8'h10, m, m, ok);
    chk(ok, "no suspend at transfer limit");
    rd(8'h08, d);
    chk(d === t, "moved total");
  endtask : limit_case
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    {reg_wr, reg_rd, egress, dscr_eop, dscr_err, core_eop, core_bad, event_in} = '0;
    {event_in_cons, slow, reg_addr, reg_wdata} = '0;
    rows = '{'{1'b0, 8'h0c, 32'h04e00000}, '{1'b0, 8'h10, 32'h0}, '{1'b0, 8'h14, 32'h0},
      '{1'b0, 8'h40, 32'h0}, '{1'b1, 8'h0c, 32'h04fff81f}, '{1'b0, 8'h0c, 32'h04e00000},
      '{1'b1, 8'h14, 32'h3ff}, '{1'b0, 8'h14, 32'h3ff}, '{1'b1, 8'h40, 32'hffffffff}};
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a, d);
        chk(d === rows[i].d, "register value");
      end
    end
    $display("register table done");
    wr(8'h00, 32'h01020000);
    wr(8'h0c, 32'h84e00000);
    rd(8'h0c, d);
    chk(d[31] === 1'b1 && d[20] === 1'b0, "enabled lags run");
    poll(8'h0c, 32'h00100000, 32'h00100000, ok);
    chk(ok, "enabled never set");
    poll(8'h10, 32'h1, 32'h1, ok);
    chk(ok, "produce notice not logged");
    chk(irq === 1'b1, "interrupt not raised");
    pulse_event(1'b1);
    rd(8'h10, d);
    chk(d[1] === 1'b1, "consume notice not logged");
    wr(8'h14, 32'h0);
    chk(irq === 1'b0, "masked interrupt seen");
    wr(8'h10, 32'h2);
    rd(8'h10, d);
    chk(d[1] === 1'b0, "write-one clear failed");
    $display("run and notices done");
    slow = 1'b1;
    // Held across a whole buffer period so that the socket is sure to be active.
    @(negedge clk);
    core_bad = 1'b1;
    repeat (24) @(negedge clk);
    core_bad = 1'b0;
    poll(8'h10, 32'h60, 32'h60, ok);
    chk(ok, "error without suspend");
    poll(8'h0c, 32'h00080000, 32'h00080000, ok);
    chk(ok, "not suspended on error");
    wr(8'h10, 32'h3e0);
    rd(8'h0c, d);
    chk(d[19] === 1'b1 && d[17:15] === 3'h5, "resumed without falling request");
    wr(8'h0c, 32'hc4e00000);
    wr(8'h0c, 32'h84e00000);
    poll(8'h0c, 32'h00080000, 32'h0, ok);
    chk(ok, "no resume after falling request");
    $display("suspend and resume done");
    wr(8'h0c, 32'h04e00000);
    chk(abort === 1'b1, "no abort on run clear");
    poll(8'h10, 32'hffffffff, 32'h0, ok);
    chk(ok, "requests kept while disabled");
    $display("disable done");
    limit_case(32'ha4e00000, 32'h2, 32'h0a0, 32'h2);
    limit_case(32'h84e00000, 32'h60, 32'h0a0, 32'h60);
    chk(clipped_fill === 16'h0020, "fill not clipped");
    limit_case(32'ha2e00000, 32'h2, 32'h220, 32'h1);
    $display("transfer limits done");
    @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    rd(8'h0c, d);
    chk(d === 32'h04e00000, "status after second reset");
    $display("second reset done");
    wr(8'h00, 32'h01020000);
    wr(8'h0c, 32'h84e00440);
    poll(8'h0c, 32'h00038000, 32'h00008000, ok);
    chk(ok && spare_ready === 1'b0, "no stall below threshold");
    pulse_event(1'b0);
    pulse_event(1'b0);
    poll(8'h0c, 32'h0000001f, 32'h00000001, ok);
    chk(ok && spare_ready === 1'b1, "tally or ready wrong after activation");
    $display("spare gate done");
    report_and_stop();
  end
endmodule : dss_socket_bench
bind dss_socket dss_socket_assertions dss_socket_assertions_inst (.clk(clk), .srst(srst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .dscr_load_req(dscr_load_req), .dscr_index(dscr_index),
  .writeback_req(writeback_req), .event_out(event_out), .abort(abort), .irq(irq));
